// >>> bit_link_shifter.sv
`default_nettype none

package dac_serial_pkg;
    localparam int DAC_W = 18;
    localparam int SHORT_W = 16;
    localparam int CASCADE_SELECT_W = 32;
    localparam logic [5:0] LEN_SHORT = 6'h10;
    localparam logic [5:0] LEN_LONG = 6'h12;
    localparam logic [5:0] LEN_CASCADE_SELECT = 6'h20;
    localparam logic [1:0] PAD_ZEROS = 2'h0;
    localparam int MIN_SPACING_NORMAL = 24;
    localparam int MIN_SPACING_CASCADE_SELECT = 40;
    localparam logic [DAC_W-1:0] DAC_RESET = 18'h00000;
    localparam logic FRAME_REQ_RESET = 1'b1;

    typedef enum logic [1:0] {
        L_IDLE = 2'b01,
        L_CAPT = 2'b10
    } link_state_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } sys_state_t;

    function automatic logic [DAC_W-1:0] pad_short(
        input logic [SHORT_W-1:0] w
    );
        pad_short = {w, PAD_ZEROS};
    endfunction : pad_short
endpackage : dac_serial_pkg

module bit_link_shifter
    import dac_serial_pkg::*;
(
    input wire logic i_bit_clk,
    input wire logic i_nrst,
    input wire logic i_start_toggle,
    input wire logic i_serial_in_a,
    input wire logic i_serial_in_b,
    input wire logic i_word_length_select,
    input wire logic i_cascade_select,
    input wire logic i_sync_polarity_select,
    output logic o_frame_request,
    output logic [DAC_W-1:0] o_word_a,
    output logic [DAC_W-1:0] o_word_b,
    output logic o_done_toggle
);
    typedef struct packed {
        link_state_t state;
        logic start_s1;
        logic start_s2;
        logic start_prev;
        logic wl_s1;
        logic wl_s2;
        logic cascade_select_s1;
        logic cascade_select_s2;
        logic pol_s1;
        logic pol_s2;
        logic frame_req;
        logic [5:0] cnt;
        logic [CASCADE_SELECT_W-1:0] shift_a;
        logic [DAC_W-1:0] shift_b;
        logic [DAC_W-1:0] word_a;
        logic [DAC_W-1:0] word_b;
        logic done_tgl;
    } link_regs_t;

    link_regs_t r_reg;
    link_regs_t r_next;

    always_comb begin
        logic [5:0] last;
        last = 6'h00;
        r_next = r_reg;
        r_next.start_s1 = i_start_toggle;
        r_next.start_s2 = r_reg.start_s1;
        r_next.start_prev = r_reg.start_s2;
        r_next.wl_s1 = i_word_length_select;
        r_next.wl_s2 = r_reg.wl_s1;
        r_next.cascade_select_s1 = i_cascade_select;
        r_next.cascade_select_s2 = r_reg.cascade_select_s1;
        r_next.pol_s1 = i_sync_polarity_select;
        r_next.pol_s2 = r_reg.pol_s1;
        // Idle level is the inverse of the active level
        r_next.frame_req = ~r_reg.pol_s2;
        if (r_reg.cascade_select_s2) begin
            last = LEN_CASCADE_SELECT - 6'h01;
        end else if (r_reg.wl_s2) begin
            last = LEN_SHORT - 6'h01;
        end else begin
            last = LEN_LONG - 6'h01;
        end
        unique case (r_reg.state)
            L_IDLE: begin
                // Extra serial bits after a full word are ignored
                r_next.cnt = r_reg.cnt;
            end
            L_CAPT: begin
                // Sampled on the rising bit clock edge, MSB first
                r_next.shift_a = {r_reg.shift_a[CASCADE_SELECT_W-2:0],
                    i_serial_in_a};
                r_next.shift_b = {r_reg.shift_b[DAC_W-2:0],
                    i_serial_in_b};
                r_next.cnt = r_reg.cnt + 6'h01;
                if (r_reg.cnt == last) begin
                    if (r_reg.cascade_select_s2) begin
                        // First half to A, second half to B
                        r_next.word_a = pad_short(
                            r_next.shift_a[CASCADE_SELECT_W-1:SHORT_W]);
                        r_next.word_b = pad_short(
                            r_next.shift_a[SHORT_W-1:0]);
                    end else if (r_reg.wl_s2) begin
                        r_next.word_a = pad_short(
                            r_next.shift_a[SHORT_W-1:0]);
                        r_next.word_b = pad_short(
                            r_next.shift_b[SHORT_W-1:0]);
                    end else begin
                        r_next.word_a = r_next.shift_a[DAC_W-1:0];
                        r_next.word_b = r_next.shift_b;
                    end
                    r_next.done_tgl = ~r_reg.done_tgl;
                    r_next.state = L_IDLE;
                end
            end
        endcase
        // A new strobe restarts capture even mid-word
        if (r_reg.start_s2 != r_reg.start_prev) begin
            r_next.frame_req = r_reg.pol_s2;
            r_next.cnt = 6'h00;
            r_next.state = L_CAPT;
        end
    end

    always_ff @(posedge i_bit_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_reg <= '0;
            r_reg.state <= L_IDLE;
            r_reg.frame_req <= FRAME_REQ_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_frame_request = r_reg.frame_req;
    assign o_word_a = r_reg.word_a;
    assign o_word_b = r_reg.word_b;
    assign o_done_toggle = r_reg.done_tgl;
endmodule : bit_link_shifter

`default_nettype wire

// >>> serial_dac_input_interface.sv
`default_nettype none

module serial_dac_input_interface
    import dac_serial_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_bit_clock_in,
    input wire logic i_convert_strobe_in,
    input wire logic i_latch_enable_n,
    input wire logic i_dac_reset_n,
    input wire logic i_sync_polarity_select,
    input wire logic i_word_length_select,
    input wire logic i_cascade_select,
    input wire logic i_serial_in_a,
    input wire logic i_serial_in_b,
    output logic o_frame_request,
    output logic [DAC_W-1:0] o_dac_a,
    output logic [DAC_W-1:0] o_dac_b,
    output logic o_dac_update
);
    typedef struct packed {
        sys_state_t state;
        logic convert_strobe_in_s1;
        logic convert_strobe_in_s2;
        logic convert_strobe_in_prev;
        logic len_s1;
        logic len_s2;
        logic rst_s1;
        logic rst_s2;
        logic done_s1;
        logic done_s2;
        logic done_prev;
        logic start_tgl;
        logic frame_zero;
        logic [DAC_W-1:0] held_a;
        logic [DAC_W-1:0] held_b;
        logic [DAC_W-1:0] dac_a;
        logic [DAC_W-1:0] dac_b;
        logic update;
    } sys_regs_t;

    sys_regs_t r_reg;
    sys_regs_t r_next;
    logic [DAC_W-1:0] link_word_a;
    logic [DAC_W-1:0] link_word_b;
    logic link_done_tgl;

    bit_link_shifter u_link (
        .i_bit_clk(i_bit_clock_in),
        .i_nrst(i_nrst),
        .i_start_toggle(r_reg.start_tgl),
        .i_serial_in_a(i_serial_in_a),
        .i_serial_in_b(i_serial_in_b),
        .i_word_length_select(i_word_length_select),
        .i_cascade_select(i_cascade_select),
        .i_sync_polarity_select(i_sync_polarity_select),
        .o_frame_request(o_frame_request),
        .o_word_a(link_word_a),
        .o_word_b(link_word_b),
        .o_done_toggle(link_done_tgl)
    );

    always_comb begin
        logic convert_strobe_in_fall;
        logic done_evt;
        convert_strobe_in_fall = 1'b0;
        done_evt = 1'b0;
        r_next = r_reg;
        // Strobe is asynchronous, so it is synchronised first
        r_next.convert_strobe_in_s1 = i_convert_strobe_in;
        r_next.convert_strobe_in_s2 = r_reg.convert_strobe_in_s1;
        r_next.convert_strobe_in_prev = r_reg.convert_strobe_in_s2;
        r_next.len_s1 = i_latch_enable_n;
        r_next.len_s2 = r_reg.len_s1;
        r_next.rst_s1 = i_dac_reset_n;
        r_next.rst_s2 = r_reg.rst_s1;
        r_next.done_s1 = link_done_tgl;
        r_next.done_s2 = r_reg.done_s1;
        r_next.done_prev = r_reg.done_s2;
        r_next.update = 1'b0;
        convert_strobe_in_fall = r_reg.convert_strobe_in_prev & ~r_reg.convert_strobe_in_s2;
        done_evt = r_reg.done_s2 ^ r_reg.done_prev;
        unique case (r_reg.state)
            ST_IDLE: begin
                r_next.state = ST_IDLE;
            end
            ST_WAIT: begin
                // Link words stay still until the next strobe
                if (done_evt) begin
                    if (r_reg.frame_zero) begin
                        r_next.held_a = DAC_RESET;
                        r_next.held_b = DAC_RESET;
                    end else begin
                        r_next.held_a = link_word_a;
                        r_next.held_b = link_word_b;
                    end
                    r_next.state = ST_IDLE;
                end
            end
        endcase
        if (convert_strobe_in_fall) begin
            if (!r_reg.len_s2) begin
                r_next.dac_a = r_reg.held_a;
                r_next.dac_b = r_reg.held_b;
                r_next.update = 1'b1;
            end
            // Enable high still restarts capture, old word dropped
            // A word landing in this same cycle is kept, not lost, unless the DAC reset is low
            r_next.held_a = r_reg.rst_s2 ? r_next.held_a : DAC_RESET;
            r_next.held_b = r_reg.rst_s2 ? r_next.held_b : DAC_RESET;
            r_next.frame_zero = ~r_reg.rst_s2;
            r_next.start_tgl = ~r_reg.start_tgl;
            r_next.state = ST_WAIT;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.dac_a <= DAC_RESET;
            r_reg.dac_b <= DAC_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_dac_a = r_reg.dac_a;
    assign o_dac_b = r_reg.dac_b;
    assign o_dac_update = r_reg.update;
endmodule : serial_dac_input_interface

`default_nettype wire

// >>> serial_dac_input_interface_monitor.sv
`default_nettype none
module serial_dac_input_interface_monitor
    import dac_serial_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_bit_clock_in,
    input wire logic i_convert_strobe_in,
    input wire logic i_latch_enable_n,
    input wire logic i_sync_polarity_select,
    input wire logic o_frame_request,
    input wire logic [DAC_W-1:0] o_dac_a,
    input wire logic [DAC_W-1:0] o_dac_b,
    input wire logic o_dac_update
);
    // Request keeps its reset level until the link sync settles
    logic [1:0] settle_reg;
    logic act;
    always_ff @(posedge i_bit_clock_in or negedge i_nrst)
        if (!i_nrst)
            settle_reg <= 2'h0;
        else if (settle_reg != 2'h3)
            settle_reg <= settle_reg + 2'h1;
    assign act = settle_reg == 2'h3 &&
        o_frame_request == i_sync_polarity_select;
    chk_upd_single: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) o_dac_update |=> !o_dac_update)
        else $error("update pulse too long");
    chk_word_update: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) ($changed(o_dac_a) || $changed(o_dac_b))
        |-> ##[0:1] o_dac_update) else $error("word changed silently");
    chk_enable_block: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) i_latch_enable_n[*4] |-> !o_dac_update)
        else $error("update while enable high");
    chk_strobe_update: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) $fell(i_convert_strobe_in) &&
        !i_latch_enable_n && !$past(i_latch_enable_n, 4)
        |-> ##[1:4] o_dac_update) else $error("strobe gave no update");
    chk_update_cause: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) o_dac_update
        |-> $past(!i_convert_strobe_in, 2)) else $error("update no strobe");
    chk_req_width: assert property (@(posedge i_bit_clock_in)
        disable iff (!i_nrst) act |=> !act[*8])
        else $error("request not one bit clock");
    chk_req_follow: assert property (@(posedge i_bit_clock_in)
        disable iff (!i_nrst) $fell(i_convert_strobe_in) &&
        settle_reg == 2'h3 |-> ##[1:6] act) else $error("no request");
    chk_req_cause: assert property (@(posedge i_bit_clock_in)
        disable iff (!i_nrst) act |-> !$past(i_convert_strobe_in))
        else $error("request without strobe");
    cover property (@(posedge i_sys_clk) o_dac_update);
    cover property (@(posedge i_bit_clock_in) act);
    cover property (@(posedge i_sys_clk)
        $fell(i_convert_strobe_in) && i_latch_enable_n);
endmodule : serial_dac_input_interface_monitor
bind serial_dac_input_interface serial_dac_input_interface_monitor u_mon (.*);
`default_nettype wire

// >>> serial_port_model.sv
`default_nettype none
module serial_port_model (
    input wire logic i_bit_clk,
    input wire logic i_frame_request,
    input wire logic i_active_level,
    input wire logic [31:0] i_word,
    input wire logic [5:0] i_len,
    output logic o_serial
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh;
    logic [5:0] n;
    initial o_serial = 1'b0;
    initial n = 6'h0;
    // Falling edge launch gives a half period around the sampling edge
    always @(negedge i_bit_clk) begin
        if (i_frame_request === i_active_level) begin
            o_serial <= i_word[31];
            sh <= i_word << 1;
            n <= i_len - 6'h1;
        end else if (n != 6'h0) begin
            o_serial <= sh[31];
            sh <= sh << 1;
            n <= n - 6'h1;
        end else begin
            // Idle line toggles so a stale bit is never trusted
            o_serial <= ~o_serial;
        end
    end
endmodule : serial_port_model
`default_nettype wire

// >>> serial_dac_input_interface_tb.sv
`default_nettype none
module serial_dac_input_interface_tb;
    import dac_serial_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, bclk = 1'b0, nrst = 1'b0, convert_strobe_in = 1'b1, en_n = 1'b0;
    logic rst_n = 1'b1, pol = 1'b0, wl = 1'b0, cascade_select = 1'b0;
    logic sa, sbm, sb, fr, upd;
    logic [31:0] wa = 32'h0, wb = 32'h0;
    logic [5:0] len = 6'h18;
    logic [DAC_W-1:0] da, db;
    int error_cnt = 0, cmp_count = 0, act_n = 0;
    always #2.5 clk = ~clk;
    always #16 bclk = ~bclk;
    // Counted mid-cycle, away from the edge that launches the request
    always @(negedge bclk) if (fr === pol) act_n++;
    assign sb = cascade_select ? sa : sbm;
    serial_dac_input_interface dut (.i_sys_clk(clk), .i_nrst(nrst),
        .i_bit_clock_in(bclk), .i_convert_strobe_in(convert_strobe_in),
        .i_latch_enable_n(en_n), .i_dac_reset_n(rst_n),
        .i_sync_polarity_select(pol), .i_word_length_select(wl),
        .i_cascade_select(cascade_select), .i_serial_in_a(sa), .i_serial_in_b(sb),
        .o_frame_request(fr), .o_dac_a(da), .o_dac_b(db),
        .o_dac_update(upd));
    serial_port_model pa (.i_bit_clk(bclk), .i_frame_request(fr),
        .i_active_level(pol), .i_word(wa), .i_len(len), .o_serial(sa));
    serial_port_model pb (.i_bit_clk(bclk), .i_frame_request(fr),
        .i_active_level(pol), .i_word(wb), .i_len(len), .o_serial(sbm));
    task automatic check(input string nm, input logic [17:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("mismatches %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // Strobe lands on a sys edge, unrelated to the bit clock
    task automatic strobe(input logic u);
        int n;
        n = 0;
        @(negedge clk) convert_strobe_in = 1'b0;
        repeat (64) @(negedge clk) if (upd === 1'b1) n++;
        @(negedge clk) convert_strobe_in = 1'b1;
        repeat (200) @(negedge clk);
        check("update count", 18'(n), u ? 18'h1 : 18'h0);
    endtask : strobe
    task automatic send(input logic [31:0] a, b, input logic e, u);
        @(negedge clk);
        wa = a;
        wb = b;
        en_n = e;
        repeat (8) @(negedge clk);
        strobe(u);
    endtask : send
    task automatic t_pol(input logic p);
        @(negedge clk) nrst = 1'b0;
        pol = p;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (60) @(negedge clk);
        check("idle level", 18'(fr), 18'(!p));
        act_n = 0;
        strobe(1'b1);
        check("request count", 18'(act_n), 18'h1);
    endtask : t_pol
    task automatic t_words(input logic w, c, input logic [5:0] l,
        input logic [31:0] a, b, input logic [17:0] ea, eb);
        wl = w;
        cascade_select = c;
        len = l;
        send(a, b, 1'b0, 1'b1);
        send(32'h0, 32'h0, 1'b0, 1'b1);
        check("word a", da, ea);
        check("word b", db, eb);
    endtask : t_words
    task automatic t_enable;
        send(32'h4000_0000, 32'h4000_0000, 1'b0, 1'b1);
        send(32'h2000_0000, 32'h2000_0000, 1'b1, 1'b0);
        check("held a", da, 18'h00000);
        send(32'h0, 32'h0, 1'b0, 1'b1);
        check("late a", da, 18'h08000);
    endtask : t_enable
    task automatic t_reset;
        rst_n = 1'b0;
        send(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 1'b1);
        send(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 1'b1);
        check("reset a", da, 18'h00000);
        rst_n = 1'b1;
        send(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 1'b1);
        check("first after", db, 18'h00000);
        send(32'h0, 32'h0, 1'b0, 1'b1);
        check("second after", db, 18'h3FFFF);
    endtask : t_reset
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        t_pol(1'b0);
        t_words(1'b1, 1'b0, 6'h18, 32'hFFFF_FFFF, 32'h0000_FFFF,
            18'h3FFFC, 18'h00000);
        // Cascade keeps word length high
        t_words(1'b1, 1'b1, 6'h28, 32'h7FFF_8000, 32'h0,
            18'h1FFFC, 18'h20000);
        t_words(1'b0, 1'b0, 6'h18, 32'h8000_3FFF, 32'h7FFF_C000,
            18'h20000, 18'h1FFFF);
        t_enable();
        t_reset();
        t_pol(1'b1);
        end_of_test();
    end
endmodule : serial_dac_input_interface_tb
`default_nettype wire
